// ---- design/termination_params.svh ----
// offsets, field positions, reset values and figures of the termination control block
`ifndef TERMINATION_PARAMS_SVH
`define TERMINATION_PARAMS_SVH

`define TC_CONFIG_OFFSET     8'h00
`define TC_MASK_OFFSET       8'h04
`define TC_STATUS_OFFSET     8'h08

`define TC_CONFIG_RESET      8'h00
`define TC_MASK_RESET        8'h00

`define TC_CA_FIELD_HI       6
`define TC_CA_FIELD_LO       4
`define TC_DATA_ENABLE_BIT   3
`define TC_DATA_FIELD_HI     2
`define TC_DATA_FIELD_LO     0

`define TC_MASK_CK_BIT       3
`define TC_MASK_CS_BIT       4
`define TC_MASK_CA_BIT       5

`define TC_OHMS_240          8'hF0
`define TC_OHMS_120          8'h78
`define TC_OHMS_80           8'h50
`define TC_OHMS_60           8'h3C
`define TC_OHMS_48           8'h30
`define TC_OHMS_40           8'h28
`define TC_OHMS_NONE         8'h00

`endif

// ---- design/termination_pkg.sv ----
// types of the termination control block
package termination_pkg;

  typedef enum logic [2:0] {
    TERM_OFF      = 3'b000,
    TERM_240      = 3'b001,
    TERM_120      = 3'b010,
    TERM_80       = 3'b011,
    TERM_60       = 3'b100,
    TERM_48       = 3'b101,
    TERM_40       = 3'b110,
    TERM_RESERVED = 3'b111
  } term_code_t;

  typedef logic [7:0]  reg_byte_t;
  typedef logic [7:0]  bus_addr_t;
  typedef logic [31:0] bus_data_t;

endpackage

// ---- design/termination_control_decode.sv ----
// termination mode registers and on/off decode for the command/address and data groups
`timescale 1ns/1ps
`default_nettype none
`include "termination_params.svh"

// What this block does
// - the command/address strength comes from config bits 6:4, codes 001 to 110 giving 240, 120, 80, 60, 48, 40 ohms.
// - after reset command/address termination stays off until software writes a valid code.
// - with the command/address field disabled, CA, clock pair and chip select are all unterminated whatever the mask says.
// - with the field enabled, CA is on unless mask bit 5, clock pair unless bit 3, chip select unless bit 4.
// - command/address termination is steered by register contents only, with no control pin.
// - the data group strength comes from config bits 2:0.
// - data group termination covers the data lines, the mask/inversion line and both strobe lines.
// - after calibration at a given pull-up point the termination value may change with no recalibration.
// - data group termination is off whenever config bit 3 is zero.
module termination_control_decode (
  input  wire logic                       i_clock,
  input  wire logic                       i_rst_n,
  input  wire termination_pkg::bus_addr_t i_addr,
  input  wire termination_pkg::bus_data_t i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output var  termination_pkg::bus_data_t o_rdata,
  output var  logic                       o_ca_term_on,
  output var  logic                       o_clock_term_on,
  output var  logic                       o_select_term_on,
  output var  logic [7:0]                 o_ca_strength_ohms,
  output var  logic                       o_dq_term_on,
  output var  logic                       o_mask_inversion_term_on,
  output var  logic                       o_strobe_t_term_on,
  output var  logic                       o_strobe_c_term_on,
  output var  logic [7:0]                 o_data_strength_ohms
);
  import termination_pkg::*;

  function automatic logic [7:0] code_ohms(input term_code_t code);
    unique case (code)
      TERM_240: code_ohms = `TC_OHMS_240;
      TERM_120: code_ohms = `TC_OHMS_120;
      TERM_80:  code_ohms = `TC_OHMS_80;
      TERM_60:  code_ohms = `TC_OHMS_60;
      TERM_48:  code_ohms = `TC_OHMS_48;
      TERM_40:  code_ohms = `TC_OHMS_40;
      default:  code_ohms = `TC_OHMS_NONE;
    endcase
  endfunction

  function automatic logic code_valid(input term_code_t code);
    code_valid = (code != TERM_OFF) && (code != TERM_RESERVED);
  endfunction

  reg_byte_t termination_config;
  reg_byte_t termination_disable_mask;

  // address decode
  wire logic       config_wr;
  wire logic       mask_wr;
  wire logic       config_rd;
  wire logic       mask_rd;
  wire logic       status_rd;
  assign config_wr = i_wr && (i_addr == `TC_CONFIG_OFFSET);
  assign mask_wr   = i_wr && (i_addr == `TC_MASK_OFFSET);
  assign config_rd = i_rd && (i_addr == `TC_CONFIG_OFFSET);
  assign mask_rd   = i_rd && (i_addr == `TC_MASK_OFFSET);
  assign status_rd = i_rd && (i_addr == `TC_STATUS_OFFSET);

  // decode looks at the value being written so outputs move with the register
  wire reg_byte_t  next_config;
  wire reg_byte_t  next_mask;
  assign next_config = config_wr ? i_wdata[7:0] : termination_config;
  assign next_mask   = mask_wr ? i_wdata[7:0] : termination_disable_mask;

  wire term_code_t next_ca_code;
  wire term_code_t next_data_code;
  wire logic       next_ca_enabled;
  wire logic       next_data_enabled;
  assign next_ca_code      = term_code_t'(next_config[`TC_CA_FIELD_HI:`TC_CA_FIELD_LO]);
  assign next_data_code    = term_code_t'(next_config[`TC_DATA_FIELD_HI:`TC_DATA_FIELD_LO]);
  assign next_ca_enabled   = code_valid(next_ca_code);
  assign next_data_enabled = next_config[`TC_DATA_ENABLE_BIT] && code_valid(next_data_code);

  wire logic       next_ca_on;
  wire logic       next_ck_on;
  wire logic       next_cs_on;
  assign next_ca_on = next_ca_enabled && !next_mask[`TC_MASK_CA_BIT];
  assign next_ck_on = next_ca_enabled && !next_mask[`TC_MASK_CK_BIT];
  assign next_cs_on = next_ca_enabled && !next_mask[`TC_MASK_CS_BIT];

  wire logic [7:0] next_ca_ohms;
  wire logic [7:0] next_data_ohms;
  assign next_ca_ohms   = next_ca_enabled ? code_ohms(next_ca_code) : `TC_OHMS_NONE;
  assign next_data_ohms = next_data_enabled ? code_ohms(next_data_code) : `TC_OHMS_NONE;

  // read mux; unmapped addresses read zero
  wire logic       data_term_on;
  wire bus_data_t  status_word;
  wire bus_data_t  next_rdata;
  assign data_term_on = o_dq_term_on;
  assign status_word  = {25'h0, data_term_on, o_select_term_on, o_clock_term_on, o_ca_term_on, 3'h0};
  assign next_rdata  = config_rd ? {24'h0, termination_config} :
                       mask_rd   ? {24'h0, termination_disable_mask} :
                       status_rd ? status_word : 32'h0000_0000;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      termination_config       <= `TC_CONFIG_RESET;
      termination_disable_mask <= `TC_MASK_RESET;
    end else begin
      termination_config       <= next_config;
      termination_disable_mask <= next_mask;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_ca_term_on         <= 1'b0;
      o_clock_term_on      <= 1'b0;
      o_select_term_on     <= 1'b0;
      o_ca_strength_ohms   <= `TC_OHMS_NONE;
      o_data_strength_ohms <= `TC_OHMS_NONE;
    end else begin
      o_ca_term_on         <= next_ca_on;
      o_clock_term_on      <= next_ck_on;
      o_select_term_on     <= next_cs_on;
      o_ca_strength_ohms   <= next_ca_ohms;
      o_data_strength_ohms <= next_data_ohms;
    end
  end

  // one enable drives every pin of the data byte
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_dq_term_on             <= 1'b0;
      o_mask_inversion_term_on <= 1'b0;
      o_strobe_t_term_on       <= 1'b0;
      o_strobe_c_term_on       <= 1'b0;
    end else begin
      o_dq_term_on             <= next_data_enabled;
      o_mask_inversion_term_on <= next_data_enabled;
      o_strobe_t_term_on       <= next_data_enabled;
      o_strobe_c_term_on       <= next_data_enabled;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // checks
  wire term_code_t ca_code;
  wire term_code_t data_code;
  assign ca_code   = term_code_t'(termination_config[`TC_CA_FIELD_HI:`TC_CA_FIELD_LO]);
  assign data_code = term_code_t'(termination_config[`TC_DATA_FIELD_HI:`TC_DATA_FIELD_LO]);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence config_write_s;
    i_wr && (i_addr == `TC_CONFIG_OFFSET) && code_valid(term_code_t'(i_wdata[6:4]))
      && !termination_disable_mask[`TC_MASK_CA_BIT];
  endsequence

  sequence ca_on_next_s;
    ##1 o_ca_term_on && (o_ca_strength_ohms == code_ohms(ca_code));
  endsequence

  ca_strength_map_a: assert property (o_ca_term_on |-> o_ca_strength_ohms == code_ohms(ca_code))
    else $error("ca strength does not match config code");

  ca_reset_off_a: assert property (disable iff (1'b0) !i_rst_n |=> !o_ca_term_on && !o_clock_term_on
    && !o_select_term_on && termination_config == `TC_CONFIG_RESET)
    else $error("ca termination not off after reset");

  ca_field_off_a: assert property (!code_valid(ca_code) |->
    !o_ca_term_on && !o_clock_term_on && !o_select_term_on)
    else $error("ca group terminated with field disabled");

  mask_bits_a: assert property (code_valid(ca_code) |->
    o_ca_term_on == !termination_disable_mask[`TC_MASK_CA_BIT]
    && o_clock_term_on == !termination_disable_mask[`TC_MASK_CK_BIT]
    && o_select_term_on == !termination_disable_mask[`TC_MASK_CS_BIT])
    else $error("mask bit decode wrong");

  data_strength_a: assert property (o_dq_term_on |-> o_data_strength_ohms == code_ohms(data_code))
    else $error("data strength does not match config code");

  data_pins_a: assert property (o_dq_term_on == o_mask_inversion_term_on
    && o_strobe_t_term_on == o_strobe_c_term_on && o_dq_term_on == o_strobe_t_term_on)
    else $error("data byte pins disagree");

  data_bit3_off_a: assert property (!termination_config[`TC_DATA_ENABLE_BIT] |->
    !o_dq_term_on && o_data_strength_ohms == `TC_OHMS_NONE)
    else $error("data terminated with enable bit clear");

  reserved_code_a: assert property ((ca_code == TERM_RESERVED || ca_code == TERM_OFF) |->
    o_ca_strength_ohms == `TC_OHMS_NONE && !o_ca_term_on)
    else $error("reserved ca code selected a resistance");

  write_effect_a: assert property (config_write_s |-> ca_on_next_s)
    else $error("ca termination did not follow the config write");

  status_read_a: assert property (i_rd && (i_addr == `TC_STATUS_OFFSET) |=>
    o_rdata[6:3] == $past({o_dq_term_on, o_select_term_on, o_clock_term_on, o_ca_term_on}))
    else $error("status read returned wrong state");

  // a mask write moves the CA line enable on the edge that takes it
  mask_write_a: assert property (i_wr && (i_addr == `TC_MASK_OFFSET) && code_valid(ca_code) |=>
    o_ca_term_on == !$past(i_wdata[`TC_MASK_CA_BIT]))
    else $error("ca termination did not follow the mask write");

  ignored_write_a: assert property (i_wr && (i_addr != `TC_CONFIG_OFFSET) && (i_addr != `TC_MASK_OFFSET) |=>
    $stable(termination_config) && $stable(termination_disable_mask))
    else $error("write to an unmapped address changed a register");

endmodule
`default_nettype wire

// ---- sim/term_controller_model.sv ----
// controller model that issues register writes and reads to the termination block
`timescale 1ns/1ps
`default_nettype none
module term_controller_model (
  input  wire logic                       i_clock,
  output var  termination_pkg::bus_addr_t o_addr,
  output var  termination_pkg::bus_data_t o_wdata,
  output var  logic                       o_wr,
  output var  logic                       o_rd,
  input  wire termination_pkg::bus_data_t i_rdata
);
  import termination_pkg::*;

  // pull-up calibration point in tenths of the I/O supply
  int pullup_cal_point = 5;

  // at the 0.6 point only the 120 and 60 ohm codes are usable
  function automatic int usable_code(input int code);
    usable_code = code;
    if (pullup_cal_point == 6 && code != 2 && code != 4) begin
      usable_code = 2;
    end
  endfunction

  // a new calibration point needs a fresh calibration before traffic resumes
  task automatic set_cal_point(input int tenths);
    pullup_cal_point = tenths;
    repeat (4) @(posedge i_clock);
  endtask

  initial begin
    o_addr  = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // released address and data show the inverse of the last value, never a stale copy
  task automatic wr(input bus_addr_t a, input bus_data_t d);
    @(posedge i_clock);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input bus_addr_t a, output bus_data_t d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clock);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ---- sim/termination_control_decode_bench.sv ----
// self-checking bench of the termination control decode block
`timescale 1ns/1ps
`default_nettype none
module termination_control_decode_bench;
  import termination_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_rst_n = 1'b0;
  logic       i_wr, i_rd, ca_on, ck_on, cs_on, dq_on, mi_on, st_on, sc_on;
  bus_addr_t  i_addr;
  bus_data_t  i_wdata, o_rdata, rd_val;
  logic [7:0] ca_ohms, dq_ohms;
  int         bad_count = 0;
  int         n_checks = 0;
  int         cfg = 0;
  int         msk = 0;
  int         st = 0;
  int         k;

  always #5 i_clock = ~i_clock;

  termination_control_decode termination_control_decode_i (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_ca_term_on(ca_on), .o_clock_term_on(ck_on), .o_select_term_on(cs_on),
    .o_ca_strength_ohms(ca_ohms), .o_dq_term_on(dq_on), .o_mask_inversion_term_on(mi_on),
    .o_strobe_t_term_on(st_on), .o_strobe_c_term_on(sc_on), .o_data_strength_ohms(dq_ohms));
  term_controller_model ctl (.i_clock, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd),
    .i_rdata(o_rdata));

  function automatic int ohms(input int code);
    case (code)
      1: ohms = 240;
      2: ohms = 120;
      3: ohms = 80;
      4: ohms = 60;
      5: ohms = 48;
      6: ohms = 40;
      default: ohms = 0;
    endcase
  endfunction

  task automatic chk(input string name, input bus_data_t exp, input bus_data_t got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic check_outputs;
    int ca;
    int dq;
    ca = ohms((cfg >> 4) & 7);
    dq = cfg[3] ? ohms(cfg & 7) : 0;
    st = ((ca != 0 && !msk[5]) << 3) | ((ca != 0 && !msk[3]) << 4) | ((ca != 0 && !msk[4]) << 5) | ((dq != 0) << 6);
    chk("ca_on", st[3], ca_on);
    chk("ck_on", st[4], ck_on);
    chk("cs_on", st[5], cs_on);
    chk("ca_ohms", ca, ca_ohms);
    chk("dq_ohms", dq, dq_ohms);
    chk("data_on", st[6] ? 32'h0000_000f : 32'h0000_0000, {dq_on, mi_on, st_on, sc_on});
  endtask

  task automatic check_regs;
    ctl.rd(8'h00, rd_val);
    chk("config", cfg, rd_val);
    ctl.rd(8'h04, rd_val);
    chk("mask", msk, rd_val);
    ctl.rd(8'h08, rd_val);
    chk("status", st, rd_val);
    ctl.rd(8'h0c, rd_val);
    chk("unmapped", 0, rd_val);
  endtask

  // upper write bits are random; only the low byte is kept
  task automatic put(input bus_addr_t a, input int b);
    ctl.wr(a, $urandom & 32'hffff_ff00 | b[7:0]);
    if (a == 8'h00) cfg = b & 255;
    if (a == 8'h04) msk = b & 255;
    #1;
    check_outputs();
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hc77b));
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    check_outputs();
    check_regs();
    // every CA field code against every pattern of mask bits 5:3, mask written first
    for (k = 0; k < 64; k++) begin
      put(8'h04, (k[2:0] << 3) | ($urandom & 32'h0000_00c7));
      put(8'h00, (k[5:3] << 4) | ($urandom & 32'h0000_008f));
      check_regs();
    end
    // second reset in mid-run clears both registers again
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    cfg = 0;
    msk = 0;
    #1;
    check_outputs();
    check_regs();
    // random traffic, status and unmapped writes must be ignored
    for (k = 0; k < 48; k++) begin
      put(8'(($urandom % 4) * 4), $urandom);
      check_regs();
    end
    // at the 0.6 pull-up point only usable codes are written, with no recalibration between values
    ctl.set_cal_point(6);
    for (k = 0; k < 16; k++) begin
      put(8'h00, (ctl.usable_code($urandom % 8) << 4) | 8 | ctl.usable_code($urandom % 8));
      check_regs();
    end
    ctl.set_cal_point(5);
    report_and_stop();
  end
endmodule
`default_nettype wire
